// ---- hw/dual_dac_input_interface.v ----
// Digital front end of a dual 12-bit DAC: latching, mode demux, segments.
// Assumes pins are sampled by clk, which must outrun every pin edge.
`default_nettype none
`include "dual_dac_regs.vh"
module dual_dac_input_interface #(
  parameter WIDTH = `DAC_WIDTH
) (
  input  wire             clk,
  input  wire             nrst,
  input  wire             clkEn,
  input  wire             modeSelect,
  input  wire [WIDTH-1:0] chan_a_bus,
  input  wire [WIDTH-1:0] chan_b_bus,
  input  wire             write_strobe_a,
  input  wire             update_clock_a,
  input  wire             update_clock_b,
  input  wire             write_strobe_b,
  input  wire             gain_share_select,
  input  wire             power_down_in,
  input  wire             outReady,
  output wire             outValid,
  output reg  [WIDTH-1:0] codeA,
  output reg  [WIDTH-1:0] codeB,
  output reg  [WIDTH-1:0] codeCompA,
  output reg  [WIDTH-1:0] codeCompB,
  output reg  [126:0]     thermA,
  output reg  [126:0]     thermB,
  output reg  [4:0]       binA,
  output reg  [4:0]       binB,
  output reg              scaleFromA,
  output reg              scaleHalf,
  output reg              active,
  output reg              dividedClock
);
  // Pin 17..20 share meaning between modes; all pass two flops.
  wire pin17Lvl;
  wire pin17Rise;
  wire pin18Lvl;
  wire pin18Rise;
  wire pin19Lvl;
  wire pin19Rise;
  wire pin20Lvl;
  wire pin20Rise;
  // Pins sampled by clk: accepted word rate stays far below the limit
  edge_detect uEd17 (
    .clk   (clk),
    .nrst  (nrst),
    .clkEn (clkEn),
    .pin   (write_strobe_a),
    .level (pin17Lvl),
    .rise  (pin17Rise)
  );
  edge_detect uEd18 (
    .clk   (clk),
    .nrst  (nrst),
    .clkEn (clkEn),
    .pin   (update_clock_a),
    .level (pin18Lvl),
    .rise  (pin18Rise)
  );
  edge_detect uEd19 (
    .clk   (clk),
    .nrst  (nrst),
    .clkEn (clkEn),
    .pin   (update_clock_b),
    .level (pin19Lvl),
    .rise  (pin19Rise)
  );
  edge_detect uEd20 (
    .clk   (clk),
    .nrst  (nrst),
    .clkEn (clkEn),
    .pin   (write_strobe_b),
    .level (pin20Lvl),
    .rise  (pin20Rise)
  );

  // Data buses and static pins: two flops each, delayed to align with strobes.
  reg [WIDTH-1:0] busA1;
  reg [WIDTH-1:0] busA2;
  reg [WIDTH-1:0] busB1;
  reg [WIDTH-1:0] busB2;
  reg             mode1;
  reg             mode2;
  reg             gain1;
  reg             gain2;
  reg             pwd1;
  reg             pwd2;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busA1 <= `DAC_RESET_CODE;
      busA2 <= `DAC_RESET_CODE;
      busB1 <= `DAC_RESET_CODE;
      busB2 <= `DAC_RESET_CODE;
      mode1 <= 1'b1;
      mode2 <= 1'b1;
      gain1 <= 1'b0;
      gain2 <= 1'b0;
      pwd1  <= 1'b0;
      pwd2  <= 1'b0;
    end else if (clkEn) begin
      busA1 <= chan_a_bus;
      busA2 <= busA1;
      busB1 <= chan_b_bus;
      busB2 <= busB1;
      mode1 <= modeSelect;
      mode2 <= mode1;
      gain1 <= gain_share_select;
      gain2 <= gain1;
      pwd1  <= power_down_in;
      pwd2  <= pwd1;
    end
  end

  wire interleaved = (mode2 == `MODE_INTERLEAVED);
  wire clockGate   = interleaved & pin19Lvl;

  // Input latches, then converter latches.
  reg [WIDTH-1:0] inLatchA;
  reg [WIDTH-1:0] inLatchB;
  reg             div;
  reg             fifoPush;
  reg             loadA;
  reg             loadB;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      inLatchA <= `DAC_RESET_CODE;
      inLatchB <= `DAC_RESET_CODE;
      div      <= 1'b0;
      loadA    <= 1'b0;
      loadB    <= 1'b0;
    end else if (clkEn) begin
      loadA <= 1'b0;
      loadB <= 1'b0;
      if (interleaved) begin
        if (pin17Rise) begin
          if (pin20Lvl == `SEL_CHAN_A) begin
            inLatchA <= busA2;
          end else begin
            inLatchB <= busA2;
          end
        end
        if (clockGate) begin
          div <= 1'b0;
        end else if (pin18Rise) begin
          div <= ~div;
          if (!div) begin
            loadA <= 1'b1;
            loadB <= 1'b1;
          end
        end
      end else begin
        div <= 1'b0;
        if (pin17Rise) begin
          inLatchA <= busA2;
        end
        if (pin20Rise) begin
          inLatchB <= busB2;
        end
        loadA <= pin18Rise;
        loadB <= pin19Rise;
      end
    end
  end

  // Two-entry buffer holds update pairs; a load that arrives while it is full is dropped.
  localparam DEPTH = 2;
  reg [2*WIDTH+1:0] mem [0:DEPTH-1];
  reg               wrPtr;
  reg               rdPtr;
  reg [1:0]         count;
  wire              inReady = (count != 2'd2);
  wire              doPush  = clkEn & (loadA | loadB) & inReady;
  wire              doPop   = clkEn & outValid & outReady;
  assign outValid = (count != 2'd0);
  always @* begin
    fifoPush = doPush;
  end
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'd0;
    end else begin
      if (fifoPush) begin
        wrPtr <= ~wrPtr;
      end
      if (doPop) begin
        rdPtr <= ~rdPtr;
      end
      count <= count + {1'b0, fifoPush} - {1'b0, doPop};
    end
  end
  // Storage has no reset; only entries below count are ever read
  always @(posedge clk) begin
    if (fifoPush) begin
      mem[wrPtr] <= {loadA, loadB, inLatchA, inLatchB};
    end
  end

  // Thermometer decode of the upper field.
  function [126:0] therm;
    input [6:0] v;
    integer k;
    begin
      for (k = 0; k < `DAC_SEGMENTS; k = k + 1) begin
        therm[k] = (k < v);
      end
    end
  endfunction

  wire [2*WIDTH+1:0] head  = mem[rdPtr];
  wire [WIDTH-1:0]   headA = head[2*WIDTH-1:WIDTH];
  wire [WIDTH-1:0]   headB = head[WIDTH-1:0];

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      codeA        <= `DAC_RESET_CODE;
      codeB        <= `DAC_RESET_CODE;
      codeCompA    <= `DAC_CODE_MAX;
      codeCompB    <= `DAC_CODE_MAX;
      thermA       <= 127'd0;
      thermB       <= 127'd0;
      binA         <= 5'd0;
      binB         <= 5'd0;
      scaleFromA   <= 1'b0;
      scaleHalf    <= 1'b0;
      active       <= 1'b0;
      dividedClock <= 1'b0;
    end else if (clkEn) begin
      scaleFromA   <= gain2;
      scaleHalf    <= gain2;
      active       <= ~pwd2;
      dividedClock <= div;
      if (doPop && !pwd2) begin
        if (head[2*WIDTH+1]) begin
          codeA     <= headA;
          codeCompA <= `DAC_CODE_MAX - headA;
          thermA    <= therm(headA[11:5]);
          binA      <= headA[4:0];
        end
        if (head[2*WIDTH]) begin
          codeB     <= headB;
          codeCompB <= `DAC_CODE_MAX - headB;
          thermB    <= therm(headB[11:5]);
          binB      <= headB[4:0];
        end
      end
    end
  end
endmodule // dual_dac_input_interface
`default_nettype wire

// ---- hw/edge_detect.v ----
// Two-flop synchroniser with a rising-edge pulse for one pin.
// Assumes clk is fast enough to see every level of the pin.
`default_nettype none
module edge_detect (
  input  wire clk,
  input  wire nrst,
  input  wire clkEn,
  input  wire pin,
  output wire level,
  output wire rise
);
  reg stage1;
  reg stage2;
  reg stage3;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else if (clkEn) begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end
  assign level = stage2;
  assign rise  = clkEn & stage2 & ~stage3;
endmodule // edge_detect
`default_nettype wire

// ---- inc/dual_dac_regs.vh ----
// Constants for the dual DAC digital front end.
// Assumes inclusion by the design files under hw/.
// Operation
// - Code splits into 7 thermometer, 5 binary bits
// - Inputs unsigned straight binary, bit 11 MSB
// - Mode low interleaved, high dual-port
// - Dual-port uses own bus, strobe, clock
// - Write strobe rise captures bus into latch
// - Update clock rise moves word to output
// - Interleaved shares bus A, strobe, clock
// - Interleaved strobe rise steers by select
// - Interleaved clock halved loads both channels
// - Gate high blocks updates and divider
// - Update rate at most 125 Msps
// - Gain share high uses resistor A halved
// - Power-down high makes device inactive
// - Outputs proportional to code and 4095-code
`ifndef DUAL_DAC_REGS_VH
`define DUAL_DAC_REGS_VH
`define DAC_WIDTH      12
`define DAC_THERM_BITS 7
`define DAC_BIN_BITS   5
`define DAC_SEGMENTS   127
`define DAC_CODE_MAX   12'hFFF
`define DAC_RESET_CODE 12'h000
`define SEL_CHAN_A     1'b0
`define MODE_INTERLEAVED 1'b0
`define MAX_RATE_MSPS  125
`endif

// ---- tb/dac_front_assertions.sv ----
// Port checks for the dual DAC front end.
// Assumes binding into dual_dac_input_interface with WIDTH 12.
`default_nettype none
module dac_front_checker (
  input wire logic         clk,
  input wire logic         nrst,
  input wire logic         modeSelect,
  input wire logic         update_clock_b,
  input wire logic         gain_share_select,
  input wire logic         power_down_in,
  input wire logic         outReady,
  input wire logic         outValid,
  input wire logic [11:0]  codeA,
  input wire logic [11:0]  codeB,
  input wire logic [11:0]  codeCompA,
  input wire logic [11:0]  codeCompB,
  input wire logic [126:0] thermA,
  input wire logic [126:0] thermB,
  input wire logic [4:0]   binA,
  input wire logic [4:0]   binB,
  input wire logic         scaleHalf,
  input wire logic         active,
  input wire logic         dividedClock
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  property p_comp; codeCompA == 12'hFFF - codeA; endproperty
  a_comp: assert property (p_comp) else $error("comp");
  property p_bin; binA == codeA[4:0]; endproperty
  a_bin: assert property (p_bin) else $error("bin");
  property p_therm; thermA == ({127{1'b1}} >> (7'd127 - codeA[11:5])); endproperty
  a_therm: assert property (p_therm) else $error("therm");
  property p_compB; codeCompB == 12'hFFF - codeB; endproperty
  a_compB: assert property (p_compB) else $error("comp B");
  property p_binB; binB == codeB[4:0]; endproperty
  a_binB: assert property (p_binB) else $error("bin B");
  property p_thermB; thermB == ({127{1'b1}} >> (7'd127 - codeB[11:5])); endproperty
  a_thermB: assert property (p_thermB) else $error("therm B");
  // Synchronisers restart from reset values, so wait five edges after reset
  property p_gain;
    $stable(gain_share_select)[*5] ##0 $past(nrst, 5) |-> scaleHalf == gain_share_select;
  endproperty
  a_gain: assert property (p_gain) else $error("gain");
  property p_pwr;
    $stable(power_down_in)[*5] ##0 $past(nrst, 5) |-> active != power_down_in;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power");
  // Codes may only move one edge after a pop
  property p_hold; !(outValid && outReady) |=> $stable(codeA) && $stable(codeB); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_gate; (!modeSelect && update_clock_b)[*5] |-> !dividedClock; endproperty
  a_gate: assert property (p_gate) else $error("gate");
  property p_keep; outValid && !outReady |=> outValid; endproperty
  a_keep: assert property (p_keep) else $error("lost");
  c_pop: cover property (outValid && outReady);
  c_div: cover property ($rose(dividedClock));
  c_off: cover property (!active);
endmodule // dac_front_checker
bind dual_dac_input_interface dac_front_checker chk (.clk, .nrst, .modeSelect, .update_clock_b,
  .gain_share_select, .power_down_in, .outReady, .outValid, .codeA, .codeB, .codeCompA, .codeCompB,
  .thermA, .thermB, .binA, .binB, .scaleHalf, .active, .dividedClock);
`default_nettype wire

// ---- tb/dac_source.sv ----
// Parallel word source driving data, strobe and clock pins.
// Assumes calls start at a falling edge of clk.
`default_nettype none
module dac_source (
  input  wire logic        clk,
  output var  logic [11:0] chan_a_bus,
  output var  logic [11:0] chan_b_bus,
  output var  logic        write_strobe_a,
  output var  logic        update_clock_a,
  output var  logic        update_clock_b,
  output var  logic        write_strobe_b
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {chan_a_bus, chan_b_bus, write_strobe_a, update_clock_a, update_clock_b, write_strobe_b} = 28'h0;
  // Levels last 3 cycles so the sampler sees each one
  task automatic word(input logic [11:0] a, input logic [11:0] b, input logic dual, input logic sel);
    if (!dual) write_strobe_b = sel;
    chan_a_bus = a;
    chan_b_bus = b;
    repeat (2) @(negedge clk);
    {write_strobe_a, update_clock_a} = 2'h3;
    if (dual) {update_clock_b, write_strobe_b} = 2'h3;
    repeat (3) @(negedge clk);
    {write_strobe_a, update_clock_a} = 2'h0;
    if (dual) {update_clock_b, write_strobe_b} = 2'h0;
    repeat (3) @(negedge clk);
    // Hold over: stale data no longer valid
    chan_a_bus = ~a;
    chan_b_bus = ~b;
  endtask
  // Interleaved mode reuses the channel B update clock as the gate
  task automatic gate(input logic level);
    update_clock_b = level;
  endtask
endmodule // dac_source
`default_nettype wire

// ---- tb/test_dual_dac_input_interface.sv ----
// Self-checking bench with a queue model of the update path.
// Assumes the source model and checker are compiled first.
`default_nettype none
module test_dual_dac_input_interface;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, clkEn, modeSelect, gain_share_select, power_down_in, outReady;
  logic outValid, scaleFromA, scaleHalf, active, dividedClock;
  logic write_strobe_a, update_clock_a, update_clock_b, write_strobe_b;
  logic [11:0] chan_a_bus, chan_b_bus, codeA, codeB, codeCompA, a, b, ea, eb, latA, latB;
  logic [126:0] thermA;
  logic [4:0] binA;
  int fail_count, n_tests, seed, i, k, n;
  logic [11:0] qa[$], qb[$];
  dual_dac_input_interface dut (
    .clk(clk), .nrst(nrst), .clkEn(clkEn), .modeSelect(modeSelect),
    .chan_a_bus(chan_a_bus), .chan_b_bus(chan_b_bus),
    .write_strobe_a(write_strobe_a), .update_clock_a(update_clock_a),
    .update_clock_b(update_clock_b), .write_strobe_b(write_strobe_b),
    .gain_share_select(gain_share_select), .power_down_in(power_down_in),
    .outReady(outReady), .outValid(outValid), .codeA(codeA), .codeB(codeB),
    .codeCompA(codeCompA), .codeCompB(), .thermA(thermA), .thermB(), .binA(binA), .binB(),
    .scaleFromA(scaleFromA), .scaleHalf(scaleHalf), .active(active), .dividedClock(dividedClock)
  );
  dac_source src (
    .clk(clk), .chan_a_bus(chan_a_bus), .chan_b_bus(chan_b_bus),
    .write_strobe_a(write_strobe_a), .update_clock_a(update_clock_a),
    .update_clock_b(update_clock_b), .write_strobe_b(write_strobe_b)
  );
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Two-entry buffer: a third word while stalled is dropped
  task automatic put(input logic dual, input logic sel);
    a = 12'($random(seed));
    b = 12'($random(seed));
    src.word(a, b, dual, sel);
    if (dual) {latA, latB} = {a, b};
    else if (sel) latB = a;
    else latA = a;
    n++;
    if ((dual || n[0]) && qa.size() < 2) begin
      qa.push_back(latA);
      qb.push_back(latB);
    end
  endtask
  task automatic drain();
    while (qa.size() > 0) begin
      a = qa.pop_front();
      b = qb.pop_front();
      for (i = 0; i < 50 && (codeA !== a || codeB !== b); i++) @(negedge clk);
      chk(codeA, a);
      chk(codeB, b);
      if (i == 50) end_of_test();
    end
  endtask
  initial begin
    {nrst, clkEn, gain_share_select, power_down_in, outReady, modeSelect} = 6'h11;
    {seed, latA, latB} = {32'h8, 24'h0};
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    chk(codeCompA, 12'hFFF);
    outReady = 1'b1;
    for (k = 0; k < 4; k++) begin
      put(1'b1, 1'b0);
      drain();
    end
    outReady = 1'b0;
    repeat (3) put(1'b1, 1'b0);
    chk({11'h0, outValid}, 12'h001);
    outReady = 1'b1;
    drain();
    {ea, eb} = {a, b};
    {power_down_in, gain_share_select} = 2'h3;
    repeat (6) @(negedge clk);
    chk({9'h0, active, scaleHalf, scaleFromA}, 12'h003);
    put(1'b1, 1'b0);
    repeat (20) @(negedge clk);
    chk(codeA, ea);
    chk(codeB, eb);
    qa.delete();
    qb.delete();
    {power_down_in, gain_share_select, modeSelect} = 3'h0;
    src.gate(1'b1);
    repeat (8) @(negedge clk);
    chk({11'h0, dividedClock}, 12'h000);
    src.gate(1'b0);
    n = 0;
    for (k = 0; k < 6; k++) begin
      put(1'b0, k[0]);
      drain();
    end
    end_of_test();
  end
endmodule // test_dual_dac_input_interface
`default_nettype wire
